//--- pkg/pefu_pkg.sv
// Package for the event flag unit: register offsets, bit positions, resets, timing.
// Assumes a 25 MHz system clock and a simple strobe register port.
package pefu_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_MHZ = 25;
   localparam int unsigned SHORT_DEBOUNCE_US = 1000;
   localparam int unsigned SHORT_CYCLES = SHORT_DEBOUNCE_US * CLK_MHZ;
   // ==========================================================
   // Register offsets
   localparam logic [3:0] OFS_FLAG_REG = 4'h0;
   localparam logic [3:0] OFS_FLAG_TOP = 4'h1;
   localparam logic [3:0] OFS_MASK_REG = 4'h2;
   localparam logic [3:0] OFS_MASK_TOP = 4'h3;
   localparam logic [3:0] OFS_STAT_REG = 4'h4;
   localparam logic [3:0] OFS_STAT_TOP = 4'h5;
   localparam logic [3:0] OFS_CONTROL = 4'h6;
   // ==========================================================
   // Regulator register fields: bit index plus regulator number
   localparam int unsigned B_ILIM = 0;
   localparam int unsigned B_SHORT = 2;
   localparam int unsigned B_POWER_OK_PIN = 4;
   localparam int unsigned B_PGFALL = 6;
   // Top register fields
   localparam int unsigned B_TWARN = 0;
   localparam int unsigned B_TSD = 1;
   localparam int unsigned B_OVP = 2;
   localparam int unsigned B_POK = 3;
   localparam int unsigned B_CLKCHG = 4;
   localparam int unsigned B_MEAS = 5;
   localparam int unsigned B_RESET = 6;
   // Control fields
   localparam int unsigned B_SWRESET = 0;
   localparam int unsigned B_POLARITY = 1;
   localparam int unsigned B_CLKDET_EN = 2;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_MASK_REG = 8'h00;
   localparam logic [7:0] RST_MASK_TOP = 8'h00;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_FLAG_TOP = 8'h40;
endpackage

//--- hw/pefu_event_flags.sv
// Event flag, mask and status logic of a dual step-down power manager.
// Assumes all event inputs synchronous to clk_sys and a strobe register port.
`timescale 1ns/1ns
module pefu_event_flags
   import pefu_pkg::*;
#(
   parameter int unsigned SHORT_COUNT = SHORT_CYCLES,
   parameter logic OTP_RESET_MASK = 1'b0
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [1:0] reg_enable,
   input wire logic [1:0] reg_in_limit,
   input wire logic [1:0] reg_output_low,
   input wire logic [1:0] reg_output_valid,
   input wire logic die_over_warning,
   input wire logic die_over_shutdown,
   input wire logic analog_supply_over,
   input wire logic power_ok_level,
   input wire logic ext_clock_present,
   input wire logic clock_detector_active,
   input wire logic current_meas_done,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   output logic interrupt_out_n,
   output logic [1:0] reg_disable,
   output logic general_output_force_low,
   output logic power_ok_pin,
   output logic software_reset_req
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0] flag_reg;
      logic [7:0] flag_top;
      logic [7:0] mask_reg;
      logic [7:0] mask_top;
      logic [7:0] control;
      logic [1:0] power_ok_pin_prev;
      logic pok_prev;
      logic clk_prev;
      logic clkdet_prev;
      logic meas_prev;
      logic [1:0] short_latched;
      logic [1:0] en_prev;
      logic [1:0][24:0] short_cnt;
      logic [7:0] rdata;
      logic irq_n;
      logic [1:0] reg_off;
      logic force_low;
      logic pin;
      logic swreset;
   } pefu_state_s;

   pefu_state_s st_q;
   pefu_state_s st_d;
   logic [7:0] stat_reg;
   logic [7:0] stat_top;
   logic [7:0] wr_reg;
   logic [7:0] wr_top;

   // ==========================================================
   // Live status
   always_comb begin
      stat_reg = 8'h00;
      stat_top = 8'h00;
      stat_reg[B_ILIM +: 2] = reg_in_limit;
      stat_reg[B_POWER_OK_PIN +: 2] = reg_output_valid;
      stat_top[B_TWARN] = die_over_warning;
      stat_top[B_TSD] = die_over_shutdown;
      stat_top[B_OVP] = analog_supply_over;
      stat_top[B_POK] = power_ok_level;
      stat_top[B_CLKCHG] = ext_clock_present;
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_d = st_q;
      wr_reg = (reg_write && reg_addr == OFS_FLAG_REG) ? reg_wdata : 8'h00;
      wr_top = (reg_write && reg_addr == OFS_FLAG_TOP) ? reg_wdata : 8'h00;
      // Clears first, then sets, so a same-cycle event wins
      st_d.flag_reg = st_q.flag_reg & ~wr_reg;
      st_d.flag_top = st_q.flag_top & ~wr_top;
      // A clear is refused only while limiting; a masked limit never sets the flag
      st_d.flag_reg[B_ILIM +: 2] = st_d.flag_reg[B_ILIM +: 2]
         | (reg_in_limit & st_q.flag_reg[B_ILIM +: 2]);
      for (int i = 0; i < 2; i++) begin
         if (reg_in_limit[i] && !st_q.mask_reg[B_ILIM + i]) begin
            st_d.flag_reg[B_ILIM + i] = 1'b1;
         end
         // Short detection: low at 1 ms after enable or low for 1 ms later
         if (!reg_enable[i] || !reg_output_low[i] || st_q.short_latched[i]) begin
            st_d.short_cnt[i] = '0;
         end else if (st_q.short_cnt[i] >= 25'(SHORT_COUNT - 1)) begin
            st_d.short_latched[i] = 1'b1;
            st_d.flag_reg[B_SHORT + i] = 1'b1;
         end else begin
            st_d.short_cnt[i] = st_q.short_cnt[i] + 25'd1;
         end
         if (reg_enable[i] && !st_q.en_prev[i]) begin
            st_d.short_latched[i] = 1'b0;
         end
         if (reg_output_valid[i] && !st_q.power_ok_pin_prev[i] && !st_q.mask_reg[B_POWER_OK_PIN + i]) begin
            st_d.flag_reg[B_POWER_OK_PIN + i] = 1'b1;
         end
         if (!reg_output_valid[i] && st_q.power_ok_pin_prev[i] && !st_q.mask_reg[B_PGFALL + i]) begin
            st_d.flag_reg[B_POWER_OK_PIN + i] = 1'b1;
         end
      end
      st_d.en_prev = reg_enable;
      st_d.power_ok_pin_prev = reg_output_valid;
      if (die_over_warning && !st_q.mask_top[B_TWARN]) begin
         st_d.flag_top[B_TWARN] = 1'b1;
      end
      if (die_over_shutdown) begin
         st_d.flag_top[B_TSD] = 1'b1;
      end
      if (analog_supply_over) begin
         st_d.flag_top[B_OVP] = 1'b1;
      end
      if (!power_ok_level && st_q.pok_prev && !st_q.mask_top[B_POK]) begin
         st_d.flag_top[B_POK] = 1'b1;
      end
      if (((clock_detector_active && ext_clock_present != st_q.clk_prev)
            || (st_q.control[B_CLKDET_EN] && !st_q.clkdet_prev && !ext_clock_present))
            && !st_q.mask_top[B_CLKCHG]) begin
         st_d.flag_top[B_CLKCHG] = 1'b1;
      end
      if (current_meas_done && !st_q.meas_prev && !st_q.mask_top[B_MEAS]) begin
         st_d.flag_top[B_MEAS] = 1'b1;
      end
      st_d.pok_prev = power_ok_level;
      st_d.clk_prev = ext_clock_present;
      st_d.clkdet_prev = st_q.control[B_CLKDET_EN];
      st_d.meas_prev = current_meas_done;
      // Register writes
      if (reg_write) begin
         unique case (reg_addr)
            OFS_MASK_REG: st_d.mask_reg = reg_wdata;
            OFS_MASK_TOP: begin
               st_d.mask_top = reg_wdata;
               st_d.mask_top[B_RESET] = st_q.mask_top[B_RESET];
            end
            OFS_CONTROL: st_d.control = reg_wdata;
            default: ;
         endcase
      end
      st_d.swreset = reg_write && reg_addr == OFS_CONTROL && reg_wdata[B_SWRESET];
      st_d.control[B_SWRESET] = 1'b0;
      // Reads: data in the following cycle only
      st_d.rdata = 8'h00;
      if (reg_read) begin
         unique case (reg_addr)
            OFS_FLAG_REG: st_d.rdata = st_q.flag_reg;
            OFS_FLAG_TOP: st_d.rdata = st_q.flag_top;
            OFS_MASK_REG: st_d.rdata = st_q.mask_reg;
            OFS_MASK_TOP: st_d.rdata = st_q.mask_top;
            OFS_STAT_REG: st_d.rdata = stat_reg;
            OFS_STAT_TOP: st_d.rdata = stat_top;
            OFS_CONTROL: st_d.rdata = st_q.control;
            default: st_d.rdata = 8'h00;
         endcase
      end
      st_d.irq_n = ~(|st_d.flag_reg || |st_d.flag_top);
      st_d.reg_off = st_d.short_latched
         | {2{die_over_shutdown || analog_supply_over}};
      st_d.force_low = die_over_shutdown || analog_supply_over;
      st_d.pin = power_ok_level ^ st_q.control[B_POLARITY];
   end

   // ==========================================================
   // Registers; undervoltage and software reset both arrive on reset_n
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.mask_reg <= RST_MASK_REG;
         st_q.mask_top <= RST_MASK_TOP;
         st_q.mask_top[B_RESET] <= OTP_RESET_MASK;
         st_q.control <= RST_CONTROL;
         st_q.flag_top <= RST_FLAG_TOP;
         st_q.flag_top[B_RESET] <= RST_FLAG_TOP[B_RESET] & ~OTP_RESET_MASK;
         // Only the reset flag can stand after reset, so the line follows its mask
         st_q.irq_n <= OTP_RESET_MASK;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign interrupt_out_n = st_q.irq_n;
   assign reg_disable = st_q.reg_off;
   assign general_output_force_low = st_q.force_low;
   assign power_ok_pin = st_q.pin;
   assign software_reset_req = st_q.swreset;

   // ==========================================================
   // Checks
   a_short_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !st_q.short_latched[0] ##1 st_q.short_latched[0] |-> st_q.flag_reg[B_SHORT])
      else $error("short latch without flag");
   a_ilim_held: assert property (@(posedge clk_sys) disable iff (!reset_n)
      reg_in_limit[0] && (st_q.flag_reg[B_ILIM] || !st_q.mask_reg[B_ILIM])
      |=> st_q.flag_reg[B_ILIM])
      else $error("current limit flag dropped while limiting");
   a_tsd_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
      die_over_shutdown |=> reg_disable == 2'b11 && general_output_force_low)
      else $error("shutdown did not disable");
   a_ovp_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
      analog_supply_over |=> st_q.flag_top[B_OVP] && !interrupt_out_n)
      else $error("overvoltage flag missing");
   a_irq_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (st_q.flag_reg == 8'h00 && st_q.flag_top == 8'h00) |-> interrupt_out_n)
      else $error("interrupt without flag");
   a_pg_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
      reg_write && reg_addr == OFS_FLAG_REG && reg_wdata[B_POWER_OK_PIN]
      && !(reg_output_valid[0] ^ st_q.power_ok_pin_prev[0]) |=> !st_q.flag_reg[B_POWER_OK_PIN])
      else $error("power-good flag not cleared");
   a_swreset_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
      software_reset_req |=> !st_q.control[B_SWRESET])
      else $error("software reset bit stuck");
   a_pok_polarity: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ##1 power_ok_pin == ($past(power_ok_level) ^ $past(st_q.control[B_POLARITY])))
      else $error("pin polarity wrong");
   a_mask_warn: assert property (@(posedge clk_sys) disable iff (!reset_n)
      st_q.mask_top[B_TWARN] && !st_q.flag_top[B_TWARN] && !(reg_write) |=>
      !st_q.flag_top[B_TWARN])
      else $error("masked warning set flag");
   // ==========================================================
   // Edge sequences for the transition events
   sequence s_pg0_rise;
      !reg_output_valid[0] ##1 reg_output_valid[0];
   endsequence
   sequence s_pg0_fall;
      reg_output_valid[0] ##1 !reg_output_valid[0];
   endsequence
   sequence s_pok_drop;
      power_ok_level ##1 !power_ok_level;
   endsequence
   sequence s_meas_rise;
      !current_meas_done ##1 current_meas_done;
   endsequence
   a_pg_rise_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_pg0_rise ##0 !st_q.mask_reg[B_POWER_OK_PIN] |=> st_q.flag_reg[B_POWER_OK_PIN])
      else $error("power-good rise flag missing");
   a_pg_fall_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_pg0_fall ##0 !st_q.mask_reg[B_PGFALL] |=> st_q.flag_reg[B_POWER_OK_PIN])
      else $error("power-good fall flag missing");
   a_pok_drop_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_pok_drop ##0 !st_q.mask_top[B_POK] |=> st_q.flag_top[B_POK])
      else $error("power-ok drop flag missing");
   a_meas_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_meas_rise ##0 !st_q.mask_top[B_MEAS] |=> st_q.flag_top[B_MEAS])
      else $error("measurement flag missing");
   a_short_kept: assert property (@(posedge clk_sys) disable iff (!reset_n)
      st_q.flag_reg[B_SHORT] && !(reg_write && reg_addr == OFS_FLAG_REG
      && reg_wdata[B_SHORT]) |=> st_q.flag_reg[B_SHORT])
      else $error("short flag lost without write");
   a_short_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
      st_q.short_latched[0] |-> reg_disable[0])
      else $error("shorted regulator still enabled");
   a_warn_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
      die_over_warning && st_q.flag_top[B_TWARN] |=> st_q.flag_top[B_TWARN])
      else $error("warning flag cleared while hot");
   a_tsd_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
      die_over_shutdown |=> st_q.flag_top[B_TSD])
      else $error("shutdown flag missing");
   a_ovp_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
      analog_supply_over |=> reg_disable == 2'b11 && general_output_force_low)
      else $error("overvoltage did not disable");
   a_clk_change: assert property (@(posedge clk_sys) disable iff (!reset_n)
      clock_detector_active && !st_q.mask_top[B_CLKCHG]
      && ext_clock_present != $past(ext_clock_present) |=> st_q.flag_top[B_CLKCHG])
      else $error("clock change flag missing");
   a_irq_pending: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (|st_q.flag_reg || |st_q.flag_top) |-> !interrupt_out_n)
      else $error("flag pending but interrupt high");
   a_reset_mask: assert property (@(posedge clk_sys) disable iff (!reset_n)
      reg_write && reg_addr == OFS_MASK_TOP |=> st_q.mask_top[B_RESET] == OTP_RESET_MASK)
      else $error("reset mask changed by write");
   a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !reg_read |=> reg_rdata == 8'h00)
      else $error("read data without read");
endmodule

//--- verif/pefu_host_model.sv
// Host processor model: drives the strobe register port; the interrupt line comes in as a port but the model never reads it.
// Assumes the bench calls rd and wr right after a rising edge of clk_sys.
`timescale 1ns/1ns
module pefu_host_model (
   input wire logic clk_sys,
   output logic [3:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic interrupt_out_n
);
   // ==========================================================
   // Bus cycles, one strobe cycle each
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
      // Idle edge so a following call never reassigns the strobe in one step
      @(posedge clk_sys);
   endtask
   // Data stands only in the cycle after the strobe, so sample at its closing edge
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
   endtask
endmodule

//--- verif/pefu_event_flags_test.sv
// Self-checking bench for the event flag unit.
// Assumes the host model file is compiled first.
`timescale 1ns/1ns
module pefu_event_flags_test;
   import pefu_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] reg_enable = 2'b11, reg_in_limit = 2'b00, reg_output_low = 2'b00;
   logic [1:0] reg_output_valid = 2'b00, reg_disable;
   logic die_over_warning = 1'b0, die_over_shutdown = 1'b0, analog_supply_over = 1'b0;
   logic power_ok_level = 1'b0, ext_clock_present = 1'b0, clock_detector_active = 1'b0;
   logic current_meas_done = 1'b0, reg_write, reg_read, interrupt_out_n;
   logic general_output_force_low, power_ok_pin, software_reset_req;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   int n_errors = 0, samples_checked = 0, cycles = 0;
   logic swreq_seen = 1'b0;
   // The request is a one-cycle pulse; latch it so the check cannot miss it
   always @(posedge clk_sys) if (software_reset_req) swreq_seen <= 1'b1;
   always #20 clk_sys = ~clk_sys;
   pefu_event_flags #(.SHORT_COUNT(8)) pefu_event_flags_inst (.clk_sys(clk_sys),
      .reset_n(reset_n), .reg_enable(reg_enable), .reg_in_limit(reg_in_limit),
      .reg_output_low(reg_output_low), .reg_output_valid(reg_output_valid),
      .die_over_warning(die_over_warning), .die_over_shutdown(die_over_shutdown),
      .analog_supply_over(analog_supply_over), .power_ok_level(power_ok_level),
      .ext_clock_present(ext_clock_present), .clock_detector_active(clock_detector_active),
      .current_meas_done(current_meas_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .interrupt_out_n(interrupt_out_n), .reg_disable(reg_disable),
      .general_output_force_low(general_output_force_low), .power_ok_pin(power_ok_pin),
      .software_reset_req(software_reset_req));
   pefu_host_model pefu_host_model_inst (.clk_sys(clk_sys), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .interrupt_out_n(interrupt_out_n));
   // ==========================================================
   // Compare, wait and closing report
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
      pefu_host_model_inst.rd(a, d);
      chk(what, exp, d);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic final_report;
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Generous ceiling: all tests need well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         final_report();
      end
   end
   // ==========================================================
   // Scenarios
   task automatic t_reset_flag;
      rdchk("top flags", OFS_FLAG_TOP, RST_FLAG_TOP);
      chk("irq", 8'h00, {7'h00, interrupt_out_n});
      pefu_host_model_inst.wr(OFS_FLAG_TOP, 8'h40);
      tick(2);
      chk("irq", 8'h01, {7'h00, interrupt_out_n});
      rdchk("mask rst", OFS_MASK_REG, RST_MASK_REG);
      $display("test reset flag done");
   endtask
   task automatic t_current_limit;
      reg_in_limit <= 2'b01;
      tick(3);
      rdchk("ilim flag", OFS_FLAG_REG, 8'h01);
      rdchk("ilim stat", OFS_STAT_REG, 8'h01);
      pefu_host_model_inst.wr(OFS_FLAG_REG, 8'h01);
      rdchk("ilim held", OFS_FLAG_REG, 8'h01);
      reg_in_limit <= 2'b00;
      pefu_host_model_inst.wr(OFS_FLAG_REG, 8'h01);
      rdchk("ilim clr", OFS_FLAG_REG, 8'h00);
      pefu_host_model_inst.wr(OFS_MASK_REG, 8'h02);
      reg_in_limit <= 2'b10;
      tick(3);
      rdchk("masked flag", OFS_FLAG_REG, 8'h00);
      rdchk("masked stat", OFS_STAT_REG, 8'h02);
      chk("irq", 8'h01, {7'h00, interrupt_out_n});
      reg_in_limit <= 2'b00;
      $display("test current limit done");
   endtask
   task automatic t_overvoltage;
      analog_supply_over <= 1'b1;
      tick(3);
      chk("disable", 8'h03, {6'h00, reg_disable});
      chk("gpo low", 8'h01, {7'h00, general_output_force_low});
      pefu_host_model_inst.wr(OFS_FLAG_TOP, 8'h04);
      rdchk("ovp held", OFS_FLAG_TOP, 8'h04);
      analog_supply_over <= 1'b0;
      pefu_host_model_inst.wr(OFS_FLAG_TOP, 8'h04);
      rdchk("ovp clr", OFS_FLAG_TOP, 8'h00);
      $display("test overvoltage done");
   endtask
   task automatic t_power_ok;
      pefu_host_model_inst.wr(OFS_CONTROL, 8'h02);
      power_ok_level <= 1'b1;
      tick(3);
      chk("pin", 8'h00, {7'h00, power_ok_pin});
      rdchk("pok stat", OFS_STAT_TOP, 8'h08);
      power_ok_level <= 1'b0;
      tick(3);
      rdchk("pok drop", OFS_FLAG_TOP, 8'h08);
      pefu_host_model_inst.wr(OFS_FLAG_TOP, 8'h08);
      rdchk("pok clr", OFS_FLAG_TOP, 8'h00);
      $display("test power ok done");
   endtask
   task automatic t_soft_reset;
      pefu_host_model_inst.wr(OFS_CONTROL, 8'h03);
      tick(1);
      chk("swreq", 8'h01, {7'h00, swreq_seen});
      chk("swreq end", 8'h00, {7'h00, software_reset_req});
      rdchk("self clr", OFS_CONTROL, 8'h02);
      $display("test soft reset done");
   endtask
   initial begin
      tick(6);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      t_reset_flag();
      t_current_limit();
      t_overvoltage();
      t_power_ok();
      t_soft_reset();
      final_report();
   end
endmodule
